// file: logic/mml_link.sv
// Monitor-mode entry, mode control and single-wire serial link
`timescale 1ns/100ps

// Behaviour
// - One open-drain line, never driven high.
// - Erased reset vector enters monitor mode.
// - Erased vector fetch raises internal reset.
// - Select high takes parallel security bytes.
// - Normal entry switches to external clock after entry window.
// - Test voltage bypasses internal clock generator.
// - Test voltage makes crystal pin reset.
// - Test voltage disables watchdog, else config.
// - Forced mode keeps watchdog off.
// - Non power-on resets keep forced mode.
// - Forced mode follows clock generator selection.
// - Monitor vectors come from page FE.
// - Break sent after eight security bytes.
// - NRZ framing, equal rates both ways.
// - Received break: release two bits, echo.
// - Bit rate is crystal divided by 1024.
// - Every received byte is echoed.
// - Eleven-bit wait, break cancels command.
// - Two idle bits before echo, data.
// - Read data only after final echo; the code sends it on any txReq while idle in the command phase, after any echo.
// - Security bypass needs all eight matching.
// - Indexed read steps to next addresses.
module mml_link
  import mml_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        porReset,          // Current reset is a power-on reset
  // Pins
  input  wire logic        serialLineIn,
  output logic             serialLineOut,
  output logic             serialLineOe_n,
  input  wire logic        commSelectPin,
  input  wire logic        testVoltagePin,     // High while the test voltage is present
  input  wire logic        modeSelectHighPin,
  input  wire logic        modeSelectLowPin,
  // Vector fetch and configuration
  input  wire logic        vecFetchValid,
  input  wire logic [15:0] vecFetchData,
  input  wire logic        watchdogDisableCfg,
  input  wire logic        clockGenSelExt,
  input  wire logic [63:0] storedSecurity,    // Byte 0 in bits 7:0
  // Parallel security entry
  input  wire logic        parValid,
  input  wire logic [7:0]  parData,
  // Firmware side
  input  wire logic        cmdLastByte,
  input  wire logic        txReq,
  input  wire logic [7:0]  txData,
  output logic             txReady,
  output logic             rxValid,
  output logic [7:0]       rxData,
  output logic             cmdGo,
  output logic             cmdAbort,
  input  wire logic        idxLoad,
  input  wire logic [15:0] idxAddr,
  input  wire logic        idxStep,
  output logic [15:0]      nextAddr,
  // Mode outputs
  output logic             monitorActive,
  output logic             forcedMode,
  output logic             parallelMode,
  output logic             internalResetReq,
  output logic             clkSrcExt,
  output logic             crystalPinIsReset,
  output logic             watchdogEnable,
  output logic [7:0]       vectorPage,
  output logic             securityBypassed,
  output logic             flashReadBlock
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mml_state_t st;        // Registered state
  mml_state_t next_st;   // Next state
  logic       fallEdge;  // Start-bit edge on the synced line
  logic       tick;      // One bit period elapsed

  assign fallEdge = st.linePrev & ~st.sync2.line;
  assign tick     = (st.baudCnt == BIT_LAST);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [9:0] frame;   // Receive shifter with the new sample
    logic [7:0] secByte; // Stored byte for the current index
    logic       monNow;  // Monitor mode as decided at entry
    logic       tvOn;    // Normal monitor with test voltage
    frame   = {st.sync2.line, st.shift[9:1]};
    secByte = storedSecurity[{st.secCnt[2:0], 3'h0} +: 8];
    monNow  = 1'b0;
    tvOn    = 1'b0;
    next_st = st;
    if (!rst_n) begin
      // Reset values; forced mode survives all but power-on
      next_st            = '0;
      next_st.forcedMon  = st.forcedMon & ~porReset;
      next_st.linePrev   = 1'b1;
      next_st.sync1.line = 1'b1;                     // Idle level, no false start edge
      next_st.sync2.line = 1'b1;
      next_st.secOk      = 1'b1;
      next_st.vectorPage = next_st.forcedMon ? MON_PAGE : USER_PAGE;
    end else begin
      // Pin synchronisers and edge history
      next_st.sync1    = {serialLineIn, commSelectPin, testVoltagePin, modeSelectHighPin, modeSelectLowPin};
      next_st.sync2    = st.sync1;
      next_st.linePrev = st.sync2.line;
      // Single-cycle pulses
      next_st.intReset = 1'b0;
      next_st.rxValid  = 1'b0;
      next_st.cmdGo    = 1'b0;
      next_st.cmdAbort = 1'b0;
      // Baud divider runs freely, restarted per phase
      next_st.baudCnt  = tick ? '0 : st.baudCnt + 10'h001;

      // Erased reset vector forces monitor mode through a reset
      if (vecFetchValid && vecFetchData == ERASED_VECTOR && !st.forcedMon && !st.normalMon) begin
        next_st.forcedMon = 1'b1;
        next_st.intReset  = 1'b1;
      end

      // Indexed-read address tracking
      if (idxLoad) begin
        next_st.nextAddr = idxAddr + ADDR_STEP;
      end else if (idxStep) begin
        next_st.nextAddr = st.nextAddr + ADDR_STEP;
      end

      case (st.phase)
        // Select-pin check window after reset
        P_ENTRY: begin
          if (st.sync2.commSel) begin
            next_st.parallel = 1'b1;
          end
          if (st.entryCnt != ENTRY_LAST) begin
            next_st.entryCnt = st.entryCnt + 5'h01;
          end else begin
            monNow = st.sync2.testVolt & ~st.sync2.modeHigh & st.sync2.modeLow;
            next_st.normalMon = monNow;
            if (monNow || st.forcedMon) begin
              next_st.phase = P_IDLE;
            end
          end
        end
        // Line idle: receive, parallel entry or read data
        P_IDLE: begin
          if (fallEdge) begin
            next_st.phase    = P_RXSTART;
            next_st.baudCnt  = '0;
            next_st.fromWait = 1'b0;
          end else if (st.parallel && !st.cmdPhase && parValid) begin
            next_st.secOk  = st.secOk & (parData == secByte);
            next_st.secCnt = st.secCnt + 4'h1;
            if (st.secCnt == SEC_BYTES_LAST) begin
              next_st.bypass   = st.secOk & (parData == secByte);
              next_st.cmdPhase = 1'b1;
              next_st.shift    = BREAK_FRAME;
              next_st.after    = AFT_IDLE;
              next_st.phase    = P_TX;
              next_st.baudCnt  = '0;
              next_st.bitCnt   = '0;
            end
          end else if (st.cmdPhase && txReq) begin
            next_st.shift   = {1'b1, txData, 1'b0};
            next_st.after   = AFT_IDLE;
            next_st.phase   = P_GAP;
            next_st.baudCnt = '0;
            next_st.bitCnt  = '0;
          end
        end
        // Confirm start bit at its midpoint
        P_RXSTART: begin
          if (st.baudCnt == HALF_LAST) begin
            next_st.baudCnt = '0;
            next_st.bitCnt  = '0;
            if (!st.sync2.line) begin
              next_st.phase = P_RXBITS;
            end else begin
              next_st.phase = P_IDLE;
              next_st.cmdGo = st.fromWait;
            end
          end
        end
        // Sample data and stop bits mid-bit
        P_RXBITS: begin
          if (tick) begin
            next_st.shift = frame;
            if (st.bitCnt != RX_SAMPLES_LAST) begin
              next_st.bitCnt = st.bitCnt + 4'h1;
            end else begin
              next_st.bitCnt = '0;
              next_st.phase  = P_GAP;
              if (frame[8:1] == BREAK_BYTE && !frame[9]) begin
                // Break: stay released two bits, then echo it
                next_st.cmdAbort = st.fromWait;
                next_st.shift    = BREAK_FRAME;
                next_st.after    = AFT_IDLE;
              end else if (!st.cmdPhase) begin
                // Security byte: compare, count and echo
                next_st.secOk  = st.secOk & (frame[8:1] == secByte);
                next_st.secCnt = st.secCnt + 4'h1;
                next_st.shift  = {1'b1, frame[8:1], 1'b0};
                next_st.after  = (st.secCnt == SEC_BYTES_LAST) ? AFT_BREAK : AFT_IDLE;
              end else begin
                // Command byte: hand over and echo
                next_st.rxValid = 1'b1;
                next_st.rxData  = frame[8:1];
                next_st.cmdGo   = st.fromWait;
                next_st.shift   = {1'b1, frame[8:1], 1'b0};
                next_st.after   = cmdLastByte ? AFT_WAIT : AFT_IDLE;
              end
            end
          end
        end
        // Two released bit periods ahead of an echo or read data
        P_GAP: begin
          if (tick) begin
            if (st.bitCnt == GAP_BITS_LAST) begin
              next_st.phase  = P_TX;
              next_st.bitCnt = '0;
            end else begin
              next_st.bitCnt = st.bitCnt + 4'h1;
            end
          end
        end
        // Shift out ten bits, LSB first
        P_TX: begin
          if (tick) begin
            if (st.bitCnt != FRAME_BITS_LAST) begin
              next_st.shift  = {1'b1, st.shift[9:1]};
              next_st.bitCnt = st.bitCnt + 4'h1;
            end else begin
              next_st.bitCnt = '0;
              case (st.after)
                AFT_BREAK: begin
                  next_st.bypass   = st.secOk;
                  next_st.cmdPhase = 1'b1;
                  next_st.shift    = BREAK_FRAME;
                  next_st.after    = AFT_IDLE;
                end
                AFT_WAIT: begin
                  next_st.phase = P_WAIT;
                end
                default: begin
                  next_st.phase = P_IDLE;
                end
              endcase
            end
          end
        end
        // Eleven-bit window in which a break cancels
        P_WAIT: begin
          if (fallEdge) begin
            next_st.phase    = P_RXSTART;
            next_st.baudCnt  = '0;
            next_st.fromWait = 1'b1;
          end else if (tick) begin
            if (st.bitCnt == WAIT_BITS_LAST) begin
              next_st.cmdGo = 1'b1;
              next_st.phase = P_IDLE;
            end else begin
              next_st.bitCnt = st.bitCnt + 4'h1;
            end
          end
        end
        default: begin
          next_st.phase = P_ENTRY;
        end
      endcase

      // Line pulled low only for zero bits of a frame
      next_st.drive = (next_st.phase == P_TX) && !next_st.shift[0];

      // Mode-dependent controls
      tvOn = st.normalMon & st.sync2.testVolt;
      next_st.clkSrcExt         = tvOn | clockGenSelExt;
      next_st.crystalPinIsReset = tvOn;
      next_st.watchdogEnable    = ~st.forcedMon & ~tvOn & ~watchdogDisableCfg;
      next_st.vectorPage        = (st.normalMon | st.forcedMon) ? MON_PAGE : USER_PAGE;
      next_st.flashReadBlock    = (st.normalMon | st.forcedMon) & ~st.bypass;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serialLineOut     = LINE_LOW;
  assign serialLineOe_n    = ~st.drive;
  assign txReady           = (st.phase == P_IDLE) && st.cmdPhase && !fallEdge;
  assign rxValid           = st.rxValid;
  assign rxData            = st.rxData;
  assign cmdGo             = st.cmdGo;
  assign cmdAbort          = st.cmdAbort;
  assign nextAddr          = st.nextAddr;
  assign monitorActive     = st.normalMon | st.forcedMon;
  assign forcedMode        = st.forcedMon;
  assign parallelMode      = st.parallel;
  assign internalResetReq  = st.intReset;
  assign clkSrcExt         = st.clkSrcExt;
  assign crystalPinIsReset = st.crystalPinIsReset;
  assign watchdogEnable    = st.watchdogEnable;
  assign vectorPage        = st.vectorPage;
  assign securityBypassed  = st.bypass;
  assign flashReadBlock    = st.flashReadBlock;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  entry_window_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> (st.phase == P_ENTRY)[*8]) else $error("Entry window ended early");
  erased_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (vecFetchValid && vecFetchData == ERASED_VECTOR && !st.forcedMon && !st.normalMon)
      |=> (internalResetReq && forcedMode)) else $error("Erased vector did not force reset");
  vector_page_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(monitorActive) |-> vectorPage == MON_PAGE) else $error("Monitor vector page wrong");
  wdog_forced_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(st.forcedMon) |-> !watchdogEnable) else $error("Watchdog on in forced mode");
  wdog_voltage_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st.normalMon && st.sync2.testVolt) |=> (!watchdogEnable && crystalPinIsReset && clkSrcExt))
    else $error("Test voltage controls not applied");
  gap_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st.phase == P_GAP || st.phase == P_IDLE || st.phase == P_WAIT) |-> serialLineOe_n)
    else $error("Line driven outside a frame");
  break_echo_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st.phase == P_RXBITS && tick && st.bitCnt == RX_SAMPLES_LAST && !st.sync2.line && st.shift[9:2] == 8'h00)
      |=> (st.phase == P_GAP && st.shift == BREAK_FRAME)) else $error("Break not echoed");
  bit_period_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(serialLineOe_n) |-> (st.baudCnt == 10'h000)) else $error("Bit edge off the divider");
  wait_abort_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cmdAbort |-> !cmdGo && $past(st.fromWait)) else $error("Abort outside command wait");

endmodule

// file: logic/mml_pkg.sv
// Constants, enumerations and packed carriers for the monitor-mode serial link
package mml_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned ENTRY_CYCLES    = 24;               // Select-pin check window, crystal cycles
  localparam logic [4:0]  ENTRY_LAST      = 5'(ENTRY_CYCLES - 1);
  localparam int unsigned BAUD_DIV        = 1024;             // Crystal cycles per bit
  localparam logic [9:0]  BIT_LAST        = 10'(BAUD_DIV - 1);
  localparam logic [9:0]  HALF_LAST       = 10'(BAUD_DIV / 2 - 1);
  localparam logic [3:0]  FRAME_BITS_LAST = 4'h9;             // Ten bits per transmitted frame
  localparam logic [3:0]  RX_SAMPLES_LAST = 4'h8;             // Eight data bits plus stop
  localparam logic [3:0]  GAP_BITS_LAST   = 4'h1;             // Two idle bits before a reply
  localparam logic [3:0]  WAIT_BITS_LAST  = 4'hA;             // Eleven bits after a command
  localparam logic [3:0]  SEC_BYTES_LAST  = 4'h7;             // Eight security bytes
  localparam logic [3:0]  SEC_BYTES       = 4'h8;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [7:0]  USER_PAGE     = 8'hFF;              // Vector page in user mode
  localparam logic [7:0]  MON_PAGE      = 8'hFE;              // Vector page in monitor mode
  localparam logic [15:0] ERASED_VECTOR = 16'hFFFF;           // Reset vector of erased flash
  localparam logic [7:0]  BREAK_BYTE    = 8'h00;
  localparam logic [9:0]  BREAK_FRAME   = 10'h000;            // Start plus nine zero bits
  localparam logic        LINE_LOW      = 1'b0;               // Only level the pin is ever driven to
  localparam logic [15:0] ADDR_STEP     = 16'h0001;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {P_ENTRY, P_IDLE, P_RXSTART, P_RXBITS, P_GAP, P_TX, P_WAIT} mml_phase_t;
  typedef enum logic [1:0] {AFT_IDLE, AFT_BREAK, AFT_WAIT} mml_after_t;

  typedef struct packed {
    logic line;      // Serial line level
    logic commSel;   // Communication select
    logic testVolt;  // Test-voltage detector
    logic modeHigh;  // Mode select high
    logic modeLow;   // Mode select low
  } mml_pins_t;

  typedef struct packed {
    mml_pins_t  sync1;         // Synchroniser first stage
    mml_pins_t  sync2;         // Synchroniser second stage
    logic       linePrev;      // Line one cycle back, edge detect
    mml_phase_t phase;
    mml_after_t after;         // What follows the current frame
    logic [4:0] entryCnt;
    logic [9:0] baudCnt;
    logic [3:0] bitCnt;
    logic [9:0] shift;
    logic       drive;         // Pulling the line low
    logic       fromWait;      // Reception began inside the post-command wait
    logic [3:0] secCnt;
    logic       secOk;
    logic       bypass;
    logic       cmdPhase;
    logic       parallel;
    logic       normalMon;
    logic       forcedMon;
    logic       intReset;
    logic       rxValid;
    logic [7:0] rxData;
    logic       cmdGo;
    logic       cmdAbort;
    logic       clkSrcExt;
    logic       crystalPinIsReset;
    logic       watchdogEnable;
    logic [7:0] vectorPage;
    logic       flashReadBlock;
    logic [15:0] nextAddr;
  } mml_state_t;

endpackage

// file: verif/mml_host_model.sv
// Host computer model that sends and captures frames on the single-wire link
`timescale 1ns/100ps
module mml_host_model
  import mml_pkg::*;
(
  // Clock and line
  input  wire logic clk_sys,
  input  wire logic lineLevel,  // Resolved wire level
  output logic      hostOe_n    // Low while the host pulls the line low
);
  logic [9:0] frame;            // Last captured frame, bit 0 is start
  int         nFrames = 0;      // Frames captured so far
  int         fallCyc = 0;      // Cycle of the last device start edge
  int         cyc     = 0;      // Free-running cycle count

  initial hostOe_n = 1'b1;

  // --------------------------------------------------------------
  // Cycle count
  // --------------------------------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
  end

  // Send ten bits, first bit first, each one bit period long
  task automatic send(input logic [9:0] bits);
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys);
      hostOe_n = bits[i];
      repeat (BAUD_DIV - 1) @(negedge clk_sys);
    end
    @(negedge clk_sys);
    hostOe_n = 1'b1;
  endtask

  // --------------------------------------------------------------
  // Receiver: ignores edges made by the host itself
  // --------------------------------------------------------------
  initial begin
    forever begin
      @(negedge lineLevel);
      if (hostOe_n) begin
        fallCyc = cyc;
        for (int i = 0; i < 10; i++) begin
          repeat (i == 0 ? BAUD_DIV / 2 : BAUD_DIV) @(posedge clk_sys);
          frame[i] = lineLevel;
        end
        nFrames++;
      end
    end
  end
endmodule

// file: verif/tb_top.sv
// Self-checking testbench for the monitor-mode serial link
`timescale 1ns/100ps
module tb_top
  import mml_pkg::*;
;
  // Stimulus
  logic clk_sys = 1'b0, rst_n = 1'b0, porReset = 1'b1, commSel = 1'b0, testVolt = 1'b0;
  logic modeHigh = 1'b0, modeLow = 1'b1, vecValid = 1'b0, wdCfg = 1'b0, cgExt = 1'b0;
  logic parValid = 1'b0, cmdLast = 1'b0, txReq = 1'b0, idxLoad = 1'b0, idxStep = 1'b0;
  logic [15:0] vecData = 16'h0000, idxAddr = 16'h0000;
  logic [7:0]  parData = 8'h00, txData = 8'h00;
  logic [63:0] storedSec = 64'h0F1E2D3C4B5A6978;  // Security bytes
  // Observed
  logic oe_n, lineOut, txReady, rxValid, cmdGo, cmdAbort, monAct, forced, parMode;
  logic intRst, clkExt, xtalRst, wdEn, secBy, flashBlk;
  logic [7:0]  rxData, vecPage, rxSeen;
  logic [15:0] nextAddr;
  wire         hostOe_n;
  wire         lineLevel = oe_n & hostOe_n;  // Pulled-up wired line
  int n_mismatch = 0, compares = 0, goCnt = 0, goCyc = 0, abortCnt = 0;

  always #20 clk_sys = ~clk_sys;

  mml_link uut (.clk_sys(clk_sys), .rst_n(rst_n), .porReset(porReset), .serialLineIn(lineLevel),
    .serialLineOut(lineOut), .serialLineOe_n(oe_n), .commSelectPin(commSel), .testVoltagePin(testVolt),
    .modeSelectHighPin(modeHigh), .modeSelectLowPin(modeLow), .vecFetchValid(vecValid),
    .vecFetchData(vecData), .watchdogDisableCfg(wdCfg), .clockGenSelExt(cgExt),
    .storedSecurity(storedSec), .parValid(parValid), .parData(parData), .cmdLastByte(cmdLast),
    .txReq(txReq), .txData(txData), .txReady(txReady), .rxValid(rxValid), .rxData(rxData),
    .cmdGo(cmdGo), .cmdAbort(cmdAbort), .idxLoad(idxLoad), .idxAddr(idxAddr), .idxStep(idxStep),
    .nextAddr(nextAddr), .monitorActive(monAct), .forcedMode(forced), .parallelMode(parMode),
    .internalResetReq(intRst), .clkSrcExt(clkExt), .crystalPinIsReset(xtalRst),
    .watchdogEnable(wdEn), .vectorPage(vecPage), .securityBypassed(secBy), .flashReadBlock(flashBlk));

  mml_host_model host (.clk_sys(clk_sys), .lineLevel(lineLevel), .hostOe_n(hostOe_n));

  // ------------------------------------------------------------
  // Event capture and timeout
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rxValid === 1'b1) rxSeen <= rxData;
    if (cmdGo === 1'b1) begin
      goCnt <= goCnt + 1;
      goCyc <= host.cyc;
    end
    if (cmdAbort === 1'b1) abortCnt <= abortCnt + 1;
    if (host.cyc == 105000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic do_reset(input logic por);
    @(negedge clk_sys);
    rst_n = 1'b0;
    porReset = por;
    repeat (3) @(negedge clk_sys);
    chk("oe_n in reset", 16'h0001, 16'(oe_n));
    chk("line drive value", 16'h0000, 16'(lineOut));
    rst_n = 1'b1;
    repeat (ENTRY_CYCLES + 4) @(negedge clk_sys);
  endtask

  // Bounded wait for the next device frame, then for its last bit to end
  task automatic wait_frame(input int n0);
    for (int k = 0; k < 30000 && host.nFrames == n0; k++) @(negedge clk_sys);
    chk("frame seen", 16'h0001, 16'(host.nFrames != n0));
    repeat (BAUD_DIV / 2 + 8) @(negedge clk_sys);
  endtask

  // Erased vector forces monitor mode, kept over warm reset
  task automatic sc_forced();
    logic seen;
    do_reset(1'b1);
    chk("user mode", 16'h0000, 16'(monAct));
    @(negedge clk_sys);
    vecValid = 1'b1;
    vecData = ERASED_VECTOR;
    @(negedge clk_sys);
    vecValid = 1'b0;
    seen = intRst;
    @(negedge clk_sys);
    chk("int reset", 16'h0001, 16'(seen | intRst));
    chk("forced", 16'h0001, 16'(forced));
    do_reset(1'b0);
    chk("forced kept", 16'h0001, 16'(forced));
    chk("wd off", 16'h0000, 16'(wdEn));
    chk("clk internal", 16'h0000, 16'(clkExt));
    chk("page", 16'h00FE, 16'(vecPage));
    cgExt = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("clk external", 16'h0001, 16'(clkExt));
    cgExt = 1'b0;
    do_reset(1'b1);
    chk("forced cleared", 16'h0000, 16'(forced));
  endtask

  // Normal entry with parallel security, then test voltage removed
  task automatic sc_entry();
    int n0;
    commSel = 1'b1;
    testVolt = 1'b1;
    modeHigh = 1'b0;
    do_reset(1'b1);
    chk("monitor", 16'h0001, 16'(monAct));
    chk("parallel", 16'h0001, 16'(parMode));
    chk("page", 16'h00FE, 16'(vecPage));
    chk("wd off", 16'h0000, 16'(wdEn));
    chk("xtal reset", 16'h0001, 16'(xtalRst));
    chk("clk ext", 16'h0001, 16'(clkExt));
    chk("read block", 16'h0001, 16'(flashBlk));
    n0 = host.nFrames;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      parValid = 1'b1;
      parData = storedSec[8*i +: 8];
      @(negedge clk_sys);
      parValid = 1'b0;
      repeat (4) @(negedge clk_sys);
    end
    wait_frame(n0);
    chk("break out", 16'h0000, 16'(host.frame));
    chk("bypass", 16'h0001, 16'(secBy));
    chk("read open", 16'h0000, 16'(flashBlk));
    testVolt = 1'b0;
    commSel = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk("wd cfg", 16'h0001, 16'(wdEn));
    chk("xtal user", 16'h0000, 16'(xtalRst));
    chk("clk gen", 16'h0000, 16'(clkExt));
    wdCfg = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("wd cfg off", 16'h0000, 16'(wdEn));
  endtask

  // Last command byte echoed, eleven-bit wait, then read data
  task automatic sc_cmd();
    int n0, tEnd, g0;
    cmdLast = 1'b1;
    n0 = host.nFrames;
    g0 = goCnt;
    host.send({1'b1, 8'hA5, 1'b0});
    tEnd = host.cyc;
    wait_frame(n0);
    cmdLast = 1'b0;
    chk("echo", {6'h00, 1'b1, 8'hA5, 1'b0}, 16'(host.frame));
    chk("rx byte", 16'h00A5, 16'(rxSeen));
    chk("echo gap", 16'h0001, 16'(host.fallCyc - tEnd inside {[1530 : 1560]}));
    for (int k = 0; k < 13000 && goCnt == g0; k++) @(negedge clk_sys);
    chk("go wait", 16'h0001, 16'(goCyc - host.fallCyc - 10240 inside {[11250 : 11300]}));
    chk("tx ready", 16'h0001, 16'(txReady));
    n0 = host.nFrames;
    txReq = 1'b1;
    txData = 8'h3C;
    @(negedge clk_sys);
    txReq = 1'b0;
    wait_frame(n0);
    chk("read data", {6'h00, 1'b1, 8'h3C, 1'b0}, 16'(host.frame));
  endtask

  // Break sent in the wait window cancels the command
  task automatic sc_abort();
    int n0, g0, a0;
    cmdLast = 1'b1;
    n0 = host.nFrames;
    host.send({1'b1, 8'h5A, 1'b0});
    wait_frame(n0);
    cmdLast = 1'b0;
    repeat (BAUD_DIV) @(negedge clk_sys);
    g0 = goCnt;
    a0 = abortCnt;
    n0 = host.nFrames;
    host.send(BREAK_FRAME);
    wait_frame(n0);
    chk("break echo", 16'h0000, 16'(host.frame));
    chk("abort", 16'(a0 + 1), 16'(abortCnt));
    chk("no go", 16'(g0), 16'(goCnt));
  endtask

  // Indexed address steps
  task automatic sc_index();
    @(negedge clk_sys);
    idxLoad = 1'b1;
    idxAddr = 16'h12FF;
    @(negedge clk_sys);
    idxLoad = 1'b0;
    chk("next addr", 16'h1300, nextAddr);
    idxStep = 1'b1;
    @(negedge clk_sys);
    idxStep = 1'b0;
    chk("step addr", 16'h1301, nextAddr);
  endtask

  initial begin
    sc_forced();
    sc_entry();
    sc_index();
    sc_cmd();
    sc_abort();
    results();
  end
endmodule
